/* hdl/epdcfg_pkg.sv */
package epdcfg_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ   = 25_000_000;
  localparam int COOL_MS  = 10;
  localparam int COOL_CYC = CLK_HZ / 1000 * COOL_MS;
  localparam int INIT_CYC = 1000;
  localparam int RST_CYC  = 16;
  localparam int SUP_CYC  = 64;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_GATE  = 8'h01;
  localparam logic [7:0] CMD_GLVL  = 8'h03;
  localparam logic [7:0] CMD_SRC   = 8'h04;
  localparam logic [7:0] CMD_IPROG = 8'h08;
  localparam logic [7:0] CMD_IWR   = 8'h09;
  localparam logic [7:0] CMD_BOOST = 8'h0C;
  localparam logic [7:0] CMD_SLEEP = 8'h10;
  localparam logic [7:0] CMD_ENTRY = 8'h11;
  localparam logic [7:0] CMD_SWRST = 8'h12;
  localparam logic [7:0] CMD_HVDET = 8'h14;
  localparam logic [7:0] CMD_SUPDT = 8'h15;
  localparam logic [7:0] CMD_TSEL  = 8'h18;
  localparam logic [7:0] CMD_TEMP  = 8'h1A;

  // ****************************************************************
  // Register offsets and fields
  // ****************************************************************
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_GATE   = 6'h08;
  localparam logic [5:0] OFS_VOLT   = 6'h0C;
  localparam logic [5:0] OFS_BOOST  = 6'h10;
  localparam logic [5:0] OFS_MISC   = 6'h14;
  localparam logic [5:0] OFS_INIT   = 6'h18;
  localparam int         BIT_CLKON  = 0;
  localparam int         BIT_ANAON  = 1;
  localparam logic [1:0] CTRL_RST   = 2'h3;

  // ****************************************************************
  // Types and reset values
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE, S_INIT, S_RST, S_HV, S_SUP, S_SLEEP
  } epdcfg_st_t;

  typedef struct packed {
    logic [8:0]      gate_lines;
    logic [2:0]      gate_scan;
    logic [4:0]      high_gate_level;
    logic [7:0]      first_positive_source_level;
    logic [7:0]      second_positive_source_level;
    logic [7:0]      negative_source_level;
    logic [3:0][7:0] boost;
    logic [1:0]      sleep_mode;
    logic [2:0]      entry;
    logic [7:0]      sensor_sel;
    logic [11:0]     temperature;
    logic [7:0]      hv_param;
    logic [2:0]      supply_threshold;
  } epdcfg_cfg_t;

  localparam epdcfg_cfg_t CFG_RST = '{
    gate_lines: 9'h000, gate_scan: 3'h0, high_gate_level: 5'h00,
    first_positive_source_level: 8'h41,
    second_positive_source_level: 8'hA8,
    negative_source_level: 8'h32,
    boost: {8'h0F, 8'h96, 8'h9C, 8'h8B},
    sleep_mode: 2'h0, entry: 3'h3, sensor_sel: 8'h48,
    temperature: 12'h07F, hv_param: 8'h00, supply_threshold: 3'h4};

endpackage

/* hdl/epdcfg_top.sv */
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module epdcfg_top import epdcfg_pkg::*; #(
  parameter int COOL_CYCLES = COOL_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        dc_i,
  input  wire logic        hv_ready_i,
  input  wire logic        supply_ok_i,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             busy_o,
  output epdcfg_cfg_t      cfg_o,
  output logic [9:0]       active_lines_o,
  output logic             first_gate_select_o,
  output logic             gate_interlace_select_o,
  output logic             gate_scan_reverse_o,
  output logic [1:0]       counter_step_direction_o,
  output logic             counter_axis_select_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic            cs_s0;
    logic            cs_s1;
    logic            scl_s0;
    logic            scl_s1;
    logic            scl_prev;
    logic            sda_s0;
    logic            sda_s1;
    logic            dc_s0;
    logic            dc_s1;
    logic            hv_s0;
    logic            hv_s1;
    logic            sup_s0;
    logic            sup_s1;
    logic [6:0]      shift;
    logic [2:0]      bitcnt;
    logic [7:0]      cmd;
    logic [2:0]      idx;
    epdcfg_cfg_t     cfg;
    logic [9:0]      active;
    logic [3:0][7:0] init_code;
    epdcfg_st_t      st;
    logic [31:0]     cnt;
    logic [2:0]      loops;
    logic            hv_flag;
    logic            sup_flag;
    logic [1:0]      ctrl;
    logic            ack;
    logic [31:0]     rdata;
  } epdcfg_state_t;

  epdcfg_state_t s_q;
  epdcfg_state_t s_d;
  logic          rx_done;
  logic [7:0]    rx_byte;
  logic          rx_data;
  logic          bus_req;
  logic [31:0]   cool_target;

  function automatic logic [2:0] param_count(input logic [7:0] c);
    case (c)
      CMD_GATE, CMD_SRC:             param_count = 3'd3;
      CMD_IWR, CMD_BOOST:            param_count = 3'd4;
      CMD_TEMP:                      param_count = 3'd2;
      CMD_GLVL, CMD_SLEEP, CMD_ENTRY,
      CMD_HVDET, CMD_SUPDT, CMD_TSEL: param_count = 3'd1;
      default:                       param_count = 3'd0;
    endcase
  endfunction

  function automatic logic [31:0] reg_read(input epdcfg_state_t s,
                                           input logic [5:0] a);
    case (a)
      OFS_CTRL:   reg_read = {30'h0, s.ctrl};
      OFS_STATUS: reg_read = {s.cmd, 19'h0, s.sup_flag, s.hv_flag,
                              s.cfg.sleep_mode, s.st != S_IDLE};
      OFS_GATE:   reg_read = {13'h0, s.cfg.gate_scan, 7'h0,
                              s.cfg.gate_lines};
      OFS_VOLT:   reg_read = {s.cfg.first_positive_source_level,
                              s.cfg.second_positive_source_level,
                              s.cfg.negative_source_level, 3'h0,
                              s.cfg.high_gate_level};
      OFS_BOOST:  reg_read = s.cfg.boost;
      OFS_MISC:   reg_read = {4'h0, s.cfg.temperature,
                              s.cfg.sensor_sel, 5'h0, s.cfg.entry};
      OFS_INIT:   reg_read = s.init_code;
      default:    reg_read = 32'h0;
    endcase
  endfunction

  // ****************************************************************
  // Serial byte receiver
  // ****************************************************************
  assign rx_done = !s_q.cs_s1 && s_q.scl_s1 && !s_q.scl_prev
                   && s_q.bitcnt == 3'd7;
  assign rx_byte = {s_q.shift, s_q.sda_s1};
  assign rx_data = s_q.dc_s1;
  assign bus_req = avs_read || avs_write;
  assign cool_target = 32'(COOL_CYCLES) *
                       (32'(s_q.cfg.hv_param[6:4]) + 32'd1);

  always_comb begin
    s_d          = s_q;
    s_d.cs_s0    = cs_n_i;
    s_d.cs_s1    = s_q.cs_s0;
    s_d.scl_s0   = scl_i;
    s_d.scl_s1   = s_q.scl_s0;
    s_d.scl_prev = s_q.scl_s1;
    s_d.sda_s0   = sda_i;
    s_d.sda_s1   = s_q.sda_s0;
    s_d.dc_s0    = dc_i;
    s_d.dc_s1    = s_q.dc_s0;
    s_d.hv_s0    = hv_ready_i;
    s_d.hv_s1    = s_q.hv_s0;
    s_d.sup_s0   = supply_ok_i;
    s_d.sup_s1   = s_q.sup_s0;
    s_d.ack      = 1'b0;
    if (s_q.cs_s1) begin
      s_d.bitcnt = 3'd0;
    end else if (s_q.scl_s1 && !s_q.scl_prev) begin
      s_d.shift  = {s_q.shift[5:0], s_q.sda_s1};
      s_d.bitcnt = s_q.bitcnt + 3'd1;
    end

    // ****************************************************************
    // Command decode
    // ****************************************************************
    if (rx_done && s_q.st == S_IDLE) begin
      if (!rx_data) begin
        s_d.cmd = rx_byte;
        s_d.idx = 3'd0;
        if (rx_byte == CMD_IPROG && s_q.ctrl[BIT_CLKON]) begin
          s_d.st  = S_INIT;
          s_d.cnt = 32'd0;
        end
        if (rx_byte == CMD_SWRST) begin
          s_d.cfg            = CFG_RST;
          s_d.cfg.sleep_mode = s_q.cfg.sleep_mode;
          s_d.init_code      = '0;
          s_d.st             = S_RST;
          s_d.cnt            = 32'd0;
        end
      end else if (s_q.idx < param_count(s_q.cmd)) begin
        s_d.idx = s_q.idx + 3'd1;
        case (s_q.cmd)
          CMD_GATE: begin
            if (s_q.idx == 3'd0) s_d.cfg.gate_lines[7:0] = rx_byte;
            if (s_q.idx == 3'd1) s_d.cfg.gate_lines[8] = rx_byte[0];
            if (s_q.idx == 3'd2) s_d.cfg.gate_scan = rx_byte[2:0];
          end
          CMD_GLVL: s_d.cfg.high_gate_level = rx_byte[4:0];
          CMD_SRC: begin
            if (s_q.idx == 3'd0)
              s_d.cfg.first_positive_source_level = rx_byte;
            if (s_q.idx == 3'd1)
              s_d.cfg.second_positive_source_level = rx_byte;
            if (s_q.idx == 3'd2)
              s_d.cfg.negative_source_level = rx_byte;
          end
          CMD_IWR: s_d.init_code[s_q.idx[1:0]] = rx_byte;
          CMD_BOOST: begin
            s_d.cfg.boost[s_q.idx[1:0]] = rx_byte;
          end
          CMD_SLEEP: begin
            s_d.cfg.sleep_mode = rx_byte[1:0];
            if (rx_byte[1:0] != 2'h0) s_d.st = S_SLEEP;
          end
          CMD_ENTRY: s_d.cfg.entry = rx_byte[2:0];
          CMD_HVDET: begin
            s_d.cfg.hv_param = rx_byte;
            if (s_q.ctrl == 2'h3) begin
              s_d.st      = S_HV;
              s_d.cnt     = 32'd0;
              s_d.hv_flag = 1'b0;
              s_d.loops   = (rx_byte[2:0] == 3'd0) ? 3'd1 : rx_byte[2:0];
            end
          end
          CMD_SUPDT: begin
            s_d.cfg.supply_threshold = rx_byte[2:0];
            if (s_q.ctrl == 2'h3) begin
              s_d.st  = S_SUP;
              s_d.cnt = 32'd0;
            end
          end
          CMD_TSEL: s_d.cfg.sensor_sel = rx_byte;
          CMD_TEMP: begin
            if (s_q.idx == 3'd0)
              s_d.cfg.temperature[11:4] = rx_byte;
            else
              s_d.cfg.temperature[3:0] = rx_byte[7:4];
          end
          default: s_d.idx = s_q.idx;
        endcase
      end
    end

    // ****************************************************************
    // Busy sequencer
    // ****************************************************************
    unique case (s_q.st)
      S_IDLE, S_SLEEP: ;
      S_INIT: begin
        s_d.cnt = s_q.cnt + 32'd1;
        if (s_q.cnt == 32'(INIT_CYC - 1)) s_d.st = S_IDLE;
      end
      S_RST: begin
        s_d.cnt = s_q.cnt + 32'd1;
        if (s_q.cnt == 32'(RST_CYC - 1)) s_d.st = S_IDLE;
      end
      S_HV: begin
        s_d.cnt = s_q.cnt + 32'd1;
        if (s_q.cnt == cool_target - 32'd1) begin
          s_d.cnt = 32'd0;
          if (s_q.hv_s1) begin
            s_d.hv_flag = 1'b1;
            s_d.st      = S_IDLE;
          end else if (s_q.loops <= 3'd1) begin
            s_d.st = S_IDLE;
          end else begin
            s_d.loops = s_q.loops - 3'd1;
          end
        end
      end
      S_SUP: begin
        s_d.cnt = s_q.cnt + 32'd1;
        if (s_q.cnt == 32'(SUP_CYC - 1)) begin
          s_d.sup_flag = s_q.sup_s1;
          s_d.st       = S_IDLE;
        end
      end
    endcase

    // ****************************************************************
    // Avalon slave
    // ****************************************************************
    if (bus_req && !s_q.ack) begin
      s_d.ack = 1'b1;
      if (avs_write && avs_address == OFS_CTRL)
        s_d.ctrl = avs_writedata[1:0];
      if (avs_read)
        s_d.rdata = reg_read(s_q, avs_address);
    end
    s_d.active = 10'(s_d.cfg.gate_lines) + 10'd1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{cfg: CFG_RST, st: S_IDLE, ctrl: CTRL_RST,
               active: 10'h001, cs_s0: 1'b1, cs_s1: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_waitrequest          = bus_req && !s_q.ack;
  assign avs_readdata             = s_q.rdata;
  assign busy_o                   = s_q.st != S_IDLE;
  assign cfg_o                    = s_q.cfg;
  assign active_lines_o           = s_q.active;
  assign first_gate_select_o      = s_q.cfg.gate_scan[2];
  assign gate_interlace_select_o  = s_q.cfg.gate_scan[1];
  assign gate_scan_reverse_o      = s_q.cfg.gate_scan[0];
  assign counter_step_direction_o = s_q.cfg.entry[1:0];
  assign counter_axis_select_o    = s_q.cfg.entry[2];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence cmd_seen(logic [7:0] c);
    rx_done && !rx_data && rx_byte == c && s_q.st == S_IDLE;
  endsequence
  sequence par_seen(logic [7:0] c, logic [2:0] i);
    rx_done && rx_data && s_q.st == S_IDLE && s_q.cmd == c && s_q.idx == i;
  endsequence

  a_sleep_busy: assert property (
    s_q.cfg.sleep_mode != 2'h0 |-> busy_o)
    else $error("asleep without busy");
  a_init_busy: assert property (
    cmd_seen(CMD_IPROG) ##0 s_q.ctrl[BIT_CLKON] |=> busy_o [*8])
    else $error("initial code run not busy");
  a_init_no_clock: assert property (
    cmd_seen(CMD_IPROG) ##0 !s_q.ctrl[BIT_CLKON] |=> !busy_o)
    else $error("initial code run without clock");
  a_reset_keeps: assert property (
    cmd_seen(CMD_SWRST) |=> busy_o && cfg_o.entry == 3'h3 &&
      cfg_o.first_positive_source_level == 8'h41 &&
      cfg_o.sleep_mode == $past(cfg_o.sleep_mode))
    else $error("software reset defaults wrong");
  a_gate_ninth: assert property (
    par_seen(CMD_GATE, 3'd1) |=> ##1
      active_lines_o == 10'(cfg_o.gate_lines) + 10'd1 &&
      cfg_o.gate_lines[8] == $past(rx_byte[0], 2))
    else $error("gate count wrong");
  a_gate_first: assert property (
    par_seen(CMD_GATE, 3'd2) |=> first_gate_select_o == $past(rx_byte[2]))
    else $error("first gate select wrong");
  a_src_negative: assert property (
    par_seen(CMD_SRC, 3'd2) |=>
      cfg_o.negative_source_level == $past(rx_byte))
    else $error("negative level not stored");
  a_temp_upper: assert property (
    par_seen(CMD_TEMP, 3'd0) |=> cfg_o.temperature[11:4] == $past(rx_byte))
    else $error("temperature upper byte wrong");
  a_extra_ignored: assert property (
    rx_done && rx_data && s_q.st == S_IDLE &&
      s_q.idx >= param_count(s_q.cmd) |=> $stable(cfg_o))
    else $error("surplus byte changed setting");
  a_hv_busy: assert property (
    par_seen(CMD_HVDET, 3'd0) ##0 s_q.ctrl == 2'h3 |=>
      busy_o && !s_q.hv_flag)
    else $error("voltage check not started");
  a_bus_answer: assert property (
    bus_req && !s_q.ack |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer late");

  // ****************************************************************
  // Storage and sequencer checks
  // ****************************************************************
  sequence hv_try_end;
    s_q.st == S_HV && s_q.cnt == cool_target - 32'd1;
  endsequence
  sequence rst_run;
    busy_o [*8] ##1 busy_o [*8];
  endsequence

  a_ctrl_write: assert property (
    bus_req && !s_q.ack && avs_write && avs_address == OFS_CTRL |=>
      s_q.ctrl == $past(avs_writedata[1:0]))
    else $error("control write lost");
  a_lvl_store: assert property (
    par_seen(CMD_GLVL, 3'd0) |=> cfg_o.high_gate_level == $past(rx_byte[4:0]))
    else $error("gate level not stored");
  a_boost_last: assert property (
    par_seen(CMD_BOOST, 3'd3) |=> cfg_o.boost[3] == $past(rx_byte))
    else $error("boost duration not stored");
  a_entry_store: assert property (
    par_seen(CMD_ENTRY, 3'd0) |=>
      counter_step_direction_o == $past(rx_byte[1:0]) &&
      counter_axis_select_o == $past(rx_byte[2]))
    else $error("entry mode not stored");
  a_sensor_store: assert property (
    par_seen(CMD_TSEL, 3'd0) |=> cfg_o.sensor_sel == $past(rx_byte))
    else $error("sensor select not stored");
  a_temp_lower: assert property (
    par_seen(CMD_TEMP, 3'd1) |=>
      cfg_o.temperature[3:0] == $past(rx_byte[7:4]))
    else $error("temperature lower bits wrong");
  a_sleep_enter: assert property (
    par_seen(CMD_SLEEP, 3'd0) ##0 rx_byte[1:0] != 2'h0 |=>
      busy_o && s_q.st == S_SLEEP)
    else $error("sleep not entered");
  a_sleep_hold: assert property (
    s_q.st == S_SLEEP |=> s_q.st == S_SLEEP)
    else $error("sleep left without reset");
  a_swrst_len: assert property (
    cmd_seen(CMD_SWRST) |=> rst_run ##1 !busy_o)
    else $error("software reset length wrong");
  a_hv_stop: assert property (
    hv_try_end ##0 s_q.hv_s1 |=> !busy_o && s_q.hv_flag)
    else $error("voltage check did not stop");
  a_sup_busy: assert property (
    par_seen(CMD_SUPDT, 3'd0) ##0 s_q.ctrl == 2'h3 |=> busy_o [*8])
    else $error("supply check not busy");
  a_busy_refused: assert property (
    rx_done && s_q.st != S_IDLE |=> $stable(cfg_o))
    else $error("byte taken while busy");

endmodule

/* tb/epdcfg_host.sv */
`timescale 1ns/1ps
// ****************************************************************
// Host side of the serial command link
// ****************************************************************
module epdcfg_host (
  output logic cs_n_o,
  output logic scl_o,
  output logic sda_o,
  output logic dc_o
);
  initial begin
    cs_n_o = 1'b1;
    scl_o  = 1'b0;
    sda_o  = 1'b0;
    dc_o   = 1'b0;
  end

  // One byte per frame, MSB first; clock stands still between frames
  task automatic send(input logic dc, input logic [7:0] b);
    cs_n_o <= 1'b0;
    dc_o   <= dc;
    for (int i = 7; i >= 0; i--) begin
      sda_o <= b[i];
      #160 scl_o <= 1'b1;
      #160 scl_o <= 1'b0;
    end
    #160 cs_n_o <= 1'b1;
    sda_o <= ~b[0];
    #160;
  endtask

  // Command byte, then its parameter bytes
  task automatic cmd(input logic [7:0] c, input logic [7:0] p[$]);
    send(1'b0, c);
    foreach (p[i]) send(1'b1, p[i]);
  endtask
endmodule

/* tb/epdcfg_tb_top.sv */
`timescale 1ns/1ps
module epdcfg_tb_top import epdcfg_pkg::*; ();
  logic        clk_i, rst_n_i, hv_ready_i, supply_ok_i;
  logic        cs_n, scl, sda, dc, avs_read, avs_write;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        avs_waitrequest, busy_o, fgs, gis, gsr, cas;
  logic [1:0]  csd;
  logic [9:0]  act;
  epdcfg_cfg_t cfg_o;
  int          errors, num_checks;

  epdcfg_top #(.COOL_CYCLES(20)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .scl_i(scl),
    .sda_i(sda), .dc_i(dc), .hv_ready_i(hv_ready_i),
    .supply_ok_i(supply_ok_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .busy_o(busy_o), .cfg_o(cfg_o),
    .active_lines_o(act), .first_gate_select_o(fgs),
    .gate_interlace_select_o(gis), .gate_scan_reverse_o(gsr),
    .counter_step_direction_o(csd), .counter_axis_select_o(cas));

  epdcfg_host host (.cs_n_o(cs_n), .scl_o(scl), .sda_o(sda), .dc_o(dc));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  task automatic av(input logic w, input logic [5:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      chk("bus timeout", avs_waitrequest, 1'b0);
      finish_test();
    end
  endtask

  task automatic wait_busy(input logic v, input int m);
    int n;
    n = 0;
    while (busy_o !== v) begin
      @(posedge clk_i);
      n++;
      if (n > m) begin
        chk("busy timeout", busy_o, v);
        finish_test();
      end
    end
  endtask

  task automatic t_defaults();
    chk("source", {cfg_o.first_positive_source_level,
      cfg_o.second_positive_source_level,
      cfg_o.negative_source_level}, 32'h0041A832);
    chk("boost", cfg_o.boost, 32'h0F969C8B);
    chk("entry", {cas, csd}, 32'h3);
    chk("sensor", cfg_o.sensor_sel, 32'h48);
    chk("temp", cfg_o.temperature, 32'h07F);
    chk("threshold", cfg_o.supply_threshold, 32'h4);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_gate();
    host.cmd(8'h01, {8'h2A, 8'h01, 8'h05, 8'hFF});
    chk("lines", {cfg_o.gate_lines, act}, {9'h12A, 10'h12B});
    chk("scan", {fgs, gis, gsr}, 32'h5);
    host.cmd(8'h01, {8'h00, 8'h00, 8'h02});
    chk("lines0", act, 32'h1);
    chk("scan0", {fgs, gis, gsr}, 32'h2);
  endtask

  task automatic t_levels();
    logic [7:0] c[4] = '{8'h00, 8'h03, 8'h17, 8'h1F};
    foreach (c[i]) begin
      host.cmd(8'h03, {c[i]});
      chk("gate level", cfg_o.high_gate_level, c[i]);
    end
    host.cmd(8'h04, {8'h8E, 8'h23, 8'h3A});
    chk("source", {cfg_o.first_positive_source_level,
      cfg_o.second_positive_source_level,
      cfg_o.negative_source_level}, 32'h008E233A);
    host.cmd(8'h0C, {8'hF4, 8'h8F, 8'h80, 8'h3F});
    chk("boost", cfg_o.boost, 32'h3F808FF4);
    for (int i = 0; i < 8; i++) begin
      host.cmd(8'h11, {8'(i)});
      chk("entry", {cas, csd}, i);
    end
    host.cmd(8'h18, {8'h80});
    chk("sensor", cfg_o.sensor_sel, 32'h80);
    host.cmd(8'h1A, {8'hFF, 8'hC0});
    chk("temp", cfg_o.temperature, 32'hFFC);
  endtask

  task automatic t_swrst();
    host.send(1'b0, 8'h12);
    chk("reset busy", busy_o, 1'b1);
    wait_busy(1'b0, 40);
    t_defaults();
  endtask

  task automatic t_ops();
    host.send(1'b0, 8'h08);
    chk("init busy", busy_o, 1'b1);
    host.cmd(8'h03, {8'h05});
    wait_busy(1'b0, 1100);
    chk("refused", cfg_o.high_gate_level, 32'h0);
    av(1'b1, OFS_CTRL, 32'h0);
    host.send(1'b0, 8'h08);
    chk("init off", busy_o, 1'b0);
    host.cmd(8'h14, {8'h00});
    chk("detect off", busy_o, 1'b0);
    av(1'b1, OFS_CTRL, 32'h3);
    @(posedge clk_i);
    hv_ready_i <= 1'b1;
    host.cmd(8'h14, {8'h12});
    chk("hv busy", busy_o, 1'b1);
    wait_busy(1'b0, 60);
    av(1'b0, OFS_STATUS, 32'h0);
    chk("hv flag", rd[3], 1'b1);
    hv_ready_i <= 1'b0;
    host.cmd(8'h14, {8'h00});
    wait_busy(1'b0, 30);
    av(1'b0, OFS_STATUS, 32'h0);
    chk("hv flag0", rd[3], 1'b0);
    supply_ok_i <= 1'b1;
    host.cmd(8'h15, {8'h03});
    chk("sup busy", {busy_o, cfg_o.supply_threshold}, 32'hB);
    wait_busy(1'b0, 80);
    av(1'b0, OFS_STATUS, 32'h0);
    chk("sup flag", rd[4], 1'b1);
  endtask

  task automatic t_sleep(input logic [7:0] code);
    host.cmd(8'h10, {code});
    chk("sleep busy", busy_o, 1'b1);
    host.send(1'b0, 8'h12);
    repeat (40) @(posedge clk_i);
    chk("asleep", {busy_o, cfg_o.sleep_mode}, {1'b1, code[1:0]});
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("awake", {busy_o, cfg_o.sleep_mode}, 32'h0);
  endtask

  task automatic t_bus();
    av(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h3);
    av(1'b0, OFS_VOLT, 32'h0);
    chk("volt reg", rd, 32'h41A83200);
    av(1'b0, OFS_BOOST, 32'h0);
    chk("boost reg", rd, 32'h0F969C8B);
    av(1'b0, OFS_MISC, 32'h0);
    chk("misc reg", rd, 32'h007F4803);
    host.cmd(8'h09, {8'h11, 8'h22, 8'h33, 8'h44});
    av(1'b0, OFS_INIT, 32'h0);
    chk("init code", rd, 32'h44332211);
    av(1'b1, 6'h3C, 32'hFFFFFFFF);
    av(1'b0, 6'h3C, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask

  initial begin
    errors        = 0;
    num_checks    = 0;
    rst_n_i       = 1'b0;
    hv_ready_i    = 1'b0;
    supply_ok_i   = 1'b0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 6'h00;
    avs_writedata = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("reset busy", busy_o, 1'b0);
    t_defaults();
    t_gate();
    t_levels();
    t_swrst();
    t_ops();
    t_sleep(8'h01);
    t_sleep(8'h03);
    t_bus();
    finish_test();
  end
endmodule
